// >>> rtl/ddrcmd_consts.svh
// Timing counts and field positions shared by both ends of the command link.
// Assumes inclusion by bare name from the package; the modules take the macros from that include.
`ifndef DDRCMD_CONSTS_SVH
`define DDRCMD_CONSTS_SVH
`define DDRCMD_AP_BIT 10
`define DDRCMD_AL_MAX 3'h6
`define DDRCMD_BANKS 4
`define DDRCMD_TXSNR_CYC 8'h14
`define DDRCMD_TRFC_CYC 8'h0c
`define DDRCMD_TREFI_CYC 16'h0f3c
`define DDRCMD_POST_MAX 4'h8
`define DDRCMD_TCCD_CYC 2'h2
`define DDRCMD_WR_CYC 4'h3
`define DDRCMD_CL_CYC 4'h3
`endif

// >>> rtl/ddrcmd_ctrl.sv
// Controller end: issues commands from APB orders and keeps refresh timing.
// Assumes APB on the same clock as the device.
`timescale 1ns/1ps
module ddrcmd_ctrl
    import ddrcmd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    ddrcmd_if.ctrl pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Offsets: 0x00 command word (write issues), 0x04 status.
    typedef enum logic [1:0] {C_RUN, C_SR, C_XS} ddrcmd_cst_t;
    typedef struct packed {
        ddrcmd_cst_t cs;
        logic [7:0] wait_cnt;
        logic [1:0] ccd;
        logic [15:0] refi;
        logic [3:0] owed;
        logic need_ref;
        logic [22:0] pend;
        logic busy;
        logic cke, cs_n, ras_n, cas_n, we_n, odt;
        logic [1:0] ba;
        logic [13:0] addr;
        logic [31:0] rd;
        logic rdy, err;
    } ddrcmd_ctl_t;
    ddrcmd_ctl_t s_reg, s_next;
    ddrcmd_cmd_t pc;
    logic ok;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rdy = 1'b0;
        s_next.err = 1'b0;
        s_next.cs_n = 1'b1;
        s_next.ras_n = 1'b1;
        s_next.cas_n = 1'b1;
        s_next.we_n = 1'b1;
        pc = ddrcmd_cmd_t'(s_reg.pend[18:16]);
        ok = 1'b0;
        if (s_reg.wait_cnt != 8'h00) s_next.wait_cnt = s_reg.wait_cnt - 8'h01;
        if (s_reg.ccd != 2'h0) s_next.ccd = s_reg.ccd - 2'h1;
        if (s_reg.cs == C_RUN) begin
            s_next.refi = s_reg.refi + 16'h0001;
            if (s_reg.refi == `DDRCMD_TREFI_CYC) begin
                s_next.refi = 16'h0000;
                if (s_reg.owed != `DDRCMD_POST_MAX) s_next.owed = s_reg.owed + 4'h1;
            end
        end
        case (s_reg.cs)
            C_RUN: begin
                if (s_reg.owed == `DDRCMD_POST_MAX && s_reg.wait_cnt == 8'h00) begin
                    s_next.cs_n = 1'b0;
                    s_next.ras_n = 1'b0;
                    s_next.cas_n = 1'b0;
                    s_next.owed = s_reg.owed - 4'h1;
                    s_next.need_ref = 1'b0;
                    s_next.wait_cnt = `DDRCMD_TRFC_CYC;
                end else if (s_reg.busy && s_reg.wait_cnt == 8'h00) begin
                    ok = !((pc == DDRCMD_RD || pc == DDRCMD_WR) && s_reg.ccd != 2'h0);
                    if (pc == DDRCMD_SRE && s_reg.need_ref) begin
                        ok = 1'b0;
                        s_next.busy = 1'b0;
                    end
                    if (pc == DDRCMD_SRE && s_reg.odt) begin
                        ok = 1'b0;
                        s_next.odt = 1'b0;
                    end
                    if (ok) begin
                        s_next.busy = 1'b0;
                        s_next.ba = s_reg.pend[15:14];
                        s_next.addr = s_reg.pend[13:0];
                        case (pc)
                            DDRCMD_ACT: {s_next.cs_n, s_next.ras_n} = 2'h0;
                            DDRCMD_RD: {s_next.cs_n, s_next.cas_n} = 2'h0;
                            DDRCMD_WR: {s_next.cs_n, s_next.cas_n, s_next.we_n} = 3'h0;
                            DDRCMD_PRE: {s_next.cs_n, s_next.ras_n, s_next.we_n} = 3'h0;
                            DDRCMD_REF: begin
                                {s_next.cs_n, s_next.ras_n, s_next.cas_n} = 3'h0;
                                s_next.wait_cnt = `DDRCMD_TRFC_CYC;
                                s_next.need_ref = 1'b0;
                                if (s_reg.owed != 4'h0) s_next.owed = s_reg.owed - 4'h1;
                            end
                            DDRCMD_SRE: begin
                                {s_next.cs_n, s_next.ras_n, s_next.cas_n} = 3'h0;
                                s_next.cke = 1'b0;
                                s_next.cs = C_SR;
                            end
                            default: s_next.odt = s_reg.pend[19];
                        endcase
                        if (pc == DDRCMD_RD || pc == DDRCMD_WR) s_next.ccd = `DDRCMD_TCCD_CYC - 2'h1;
                    end
                end
            end
            C_SR: begin
                s_next.cke = 1'b0;
                if (s_reg.busy && pc == DDRCMD_NOP) begin
                    s_next.busy = 1'b0;
                    s_next.cke = 1'b1;
                    s_next.cs = C_XS;
                    s_next.wait_cnt = `DDRCMD_TXSNR_CYC;
                    s_next.need_ref = 1'b1;
                end
            end
            C_XS: begin
                s_next.cke = 1'b1;
                s_next.odt = 1'b0;
                if (s_reg.wait_cnt == 8'h01) s_next.cs = C_RUN;
            end
            default: s_next.cs = C_RUN;
        endcase
        // APB slave; command writes are refused while one is pending.
        if (psel && !penable) begin
            s_next.rdy = 1'b1;
            s_next.rd = 32'h00000000;
            if (paddr == 8'h00) begin
                if (pwrite) begin
                    if (s_reg.busy) s_next.err = 1'b1;
                end else s_next.rd = {9'h000, s_reg.pend};
            end else if (paddr == 8'h04) begin
                if (!pwrite) s_next.rd = {22'h000000, s_reg.need_ref, s_reg.owed,
                    s_reg.cs == C_XS, s_reg.cs == C_SR, s_reg.busy, 2'h0};
                else s_next.err = 1'b1;
            end else s_next.err = 1'b1;
        end
        // A command write lands at the edge where pready is sampled high.
        if (psel && penable && s_reg.rdy && pwrite && paddr == 8'h00 && !s_reg.err) begin
            s_next.pend = pwdata[22:0];
            s_next.busy = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.cke <= 1'b1;
            s_reg.cs_n <= 1'b1;
            s_reg.ras_n <= 1'b1;
            s_reg.cas_n <= 1'b1;
            s_reg.we_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins.cke = s_reg.cke;
    assign pins.cs_n = s_reg.cs_n;
    assign pins.ras_n = s_reg.ras_n;
    assign pins.cas_n = s_reg.cas_n;
    assign pins.we_n = s_reg.we_n;
    assign pins.odt = s_reg.odt;
    assign pins.ba = s_reg.ba;
    assign pins.addr = s_reg.addr;
    assign prdata = s_reg.rd;
    assign pready = s_reg.rdy;
    assign pslverr = s_reg.err;
endmodule : ddrcmd_ctrl

// >>> rtl/ddrcmd_dev.sv
// Device end: decodes commands and tracks bank, refresh and self refresh state.
// Assumes the controller keeps its timing obligations.
`timescale 1ns/1ps
module ddrcmd_dev
    import ddrcmd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    ddrcmd_if.dev pins,
    input wire logic [2:0] al,
    input wire logic bl8,
    output logic [3:0] bank_open,
    output logic self_refresh,
    output logic dll_on,
    output logic [12:0] ref_row,
    output logic col_issue,
    output logic col_write,
    output logic [1:0] col_bank,
    output logic [9:0] col_addr
);
    typedef struct packed {
        logic [3:0] open;
        logic [3:0] [5:0] ap_cnt;
        logic sr;
        logic dll;
        logic [12:0] row;
        logic [15:0] sr_tmr;
        logic [6:0] [14:0] pipe;
        logic issue;
        logic wr;
        logic [1:0] bank;
        logic [9:0] col;
    } ddrcmd_dev_t;
    ddrcmd_dev_t st_reg, st_next;
    ddrcmd_cmd_t cmd;
    logic [2:0] al_eff;
    logic [5:0] half_bl;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        cmd = ddrcmd_decode(pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.cke);
        al_eff = (al > `DDRCMD_AL_MAX) ? `DDRCMD_AL_MAX : al;
        half_bl = bl8 ? 6'h04 : 6'h02;
        st_next = st_reg;
        st_next.issue = 1'b0;
        for (int b = 0; b < `DDRCMD_BANKS; b++) begin
            if (st_reg.ap_cnt[b] != 6'h00) begin
                st_next.ap_cnt[b] = st_reg.ap_cnt[b] - 6'h01;
                if (st_reg.ap_cnt[b] == 6'h01) begin
                    st_next.open[b] = 1'b0;
                end
            end
        end
        // Posted column commands shift through a pipe of AL stages.
        st_next.pipe = {st_reg.pipe[5:0], 15'h0000};
        if (st_reg.sr) begin
            st_next.sr_tmr = st_reg.sr_tmr + 16'h0001;
            if (st_reg.sr_tmr == `DDRCMD_TREFI_CYC) begin
                st_next.sr_tmr = 16'h0000;
                st_next.row = st_reg.row + 13'h0001;
            end
            if (pins.cke) begin
                st_next.sr = 1'b0;
                st_next.dll = 1'b1;
            end
        end else begin
            case (cmd)
                DDRCMD_ACT: begin
                    st_next.open[pins.ba] = 1'b1;
                end
                DDRCMD_RD, DDRCMD_WR: begin
                    st_next.pipe[0] = {1'b1, cmd == DDRCMD_WR, pins.addr[`DDRCMD_AP_BIT],
                        pins.ba, pins.addr[9:0]};
                    if (pins.addr[`DDRCMD_AP_BIT]) begin
                        st_next.ap_cnt[pins.ba] = (cmd == DDRCMD_RD) ?
                            6'(al_eff) + half_bl :
                            6'(al_eff) + 6'(`DDRCMD_CL_CYC) - 6'h01 + half_bl
                            + 6'(`DDRCMD_WR_CYC);
                    end
                end
                DDRCMD_PRE: begin
                    if (pins.addr[`DDRCMD_AP_BIT]) begin
                        st_next.open = 4'h0;
                    end else begin
                        st_next.open[pins.ba] = 1'b0;
                    end
                end
                DDRCMD_REF: begin
                    st_next.row = st_reg.row + 13'h0001;
                    st_next.open = 4'h0;
                end
                DDRCMD_SRE: begin
                    st_next.sr = 1'b1;
                    st_next.dll = 1'b0;
                    st_next.sr_tmr = 16'h0000;
                    st_next.open = 4'h0;
                end
                default: begin
                end
            endcase
        end
        // Command leaves the pipe after AL stages, inside its segment.
        if (st_next.pipe[al_eff][14]) begin
            st_next.issue = 1'b1;
        end
        st_next.wr = st_next.pipe[al_eff][13];
        st_next.bank = st_next.pipe[al_eff][11:10];
        st_next.col = st_next.pipe[al_eff][9:0];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.dll <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bank_open = st_reg.open;
    assign self_refresh = st_reg.sr;
    assign dll_on = st_reg.dll;
    assign ref_row = st_reg.row;
    assign col_issue = st_reg.issue;
    assign col_write = st_reg.wr;
    assign col_bank = st_reg.bank;
    assign col_addr = st_reg.col;
endmodule : ddrcmd_dev

// >>> rtl/ddrcmd_if.sv
// Command pins between controller and device.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ddrcmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [1:0] ba;
    logic [13:0] addr;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface : ddrcmd_if

// >>> rtl/ddrcmd_pkg.sv
// Types shared by the device model and the controller.
// Assumes the constants header is on the include path.
`include "ddrcmd_consts.svh"
package ddrcmd_pkg;
    typedef enum logic [2:0] {DDRCMD_NOP, DDRCMD_ACT, DDRCMD_RD, DDRCMD_WR, DDRCMD_PRE,
        DDRCMD_REF, DDRCMD_SRE, DDRCMD_OTHER} ddrcmd_cmd_t;
    function automatic ddrcmd_cmd_t ddrcmd_decode(input logic cs_n, input logic ras_n,
        input logic cas_n, input logic we_n, input logic cke);
        ddrcmd_cmd_t c;
        c = DDRCMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h7: c = DDRCMD_NOP;
                3'h3: c = DDRCMD_ACT;
                3'h5: c = DDRCMD_RD;
                3'h4: c = DDRCMD_WR;
                3'h2: c = DDRCMD_PRE;
                3'h1: c = cke ? DDRCMD_REF : DDRCMD_SRE;
                default: c = DDRCMD_OTHER;
            endcase
        end
        return c;
    endfunction : ddrcmd_decode
endpackage : ddrcmd_pkg

// >>> sim/ddrcmd_properties.sv
// Checker for the command link between the controller and the device.
// Assumes the bench wires the link pins and the device status outputs in by name.
`timescale 1ns/1ps
module ddrcmd_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [1:0] ba,
    input wire logic [13:0] addr,
    input wire logic [2:0] al,
    input wire logic bl8,
    input wire logic [3:0] bank_open,
    input wire logic self_refresh,
    input wire logic dll_on
);
    // ------------------------------------------------------------
    // Command decode, counters and properties.
    // ------------------------------------------------------------
    logic sel_col, sel_ref, sel_sre, sel_nop, sel_act, sel_pall, need_ref_reg;
    logic [4:0] quiet_reg;
    logic [3:0] rfc_reg, ap_reg;
    logic [1:0] ap_bank_reg;
    logic [15:0] gap_reg;
    assign sel_col = !cs_n && ras_n && !cas_n;
    assign sel_act = !cs_n && !ras_n && cas_n && we_n;
    assign sel_pall = !cs_n && !ras_n && cas_n && !we_n && addr[10];
    assign sel_ref = !cs_n && !ras_n && !cas_n && we_n && cke;
    assign sel_sre = !cs_n && !ras_n && !cas_n && we_n && !cke;
    assign sel_nop = cs_n || (ras_n && cas_n && we_n);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_reg <= 5'h00;
            rfc_reg <= 4'h0;
            ap_reg <= 4'h0;
            ap_bank_reg <= 2'h0;
            gap_reg <= 16'h0000;
            need_ref_reg <= 1'b0;
        end else begin
            quiet_reg <= $rose(cke) ? 5'h13 : quiet_reg - 5'(quiet_reg != 5'h00);
            rfc_reg <= sel_ref ? 4'hb : rfc_reg - 4'(rfc_reg != 4'h0);
            gap_reg <= (sel_ref || !cke) ? 16'h0000 : gap_reg + 16'h0001;
            need_ref_reg <= $rose(cke) || (need_ref_reg && !sel_ref);
            if (sel_col && addr[10]) begin
                ap_reg <= 4'(al) + (bl8 ? 4'h4 : 4'h2) + (we_n ? 4'h0 : 4'h5);
                ap_bank_reg <= ba;
            end else begin
                ap_reg <= ap_reg - 4'(ap_reg != 4'h0);
            end
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_exit; self_refresh ##0 cke && sel_nop; endsequence
    sequence s_in_sr; self_refresh [*2]; endsequence
    property p_sre_odt; sel_sre |-> !odt; endproperty
    a_sre_odt: assert property (p_sre_odt) else $error("odt high at entry");
    property p_sr_enter; sel_sre |-> ##[1:2] self_refresh; endproperty
    a_sr_enter: assert property (p_sr_enter) else $error("entry not taken");
    property p_sr_stay; self_refresh && !cke |=> self_refresh; endproperty
    a_sr_stay: assert property (p_sr_stay) else $error("left self refresh early");
    property p_sr_exit; s_exit |-> ##[1:2] !self_refresh; endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("exit not taken");
    property p_dll_off; s_in_sr |-> !dll_on; endproperty
    a_dll_off: assert property (p_dll_off) else $error("dll on in self refresh");
    property p_dll_on; $fell(self_refresh) |-> ##[0:2] dll_on; endproperty
    a_dll_on: assert property (p_dll_on) else $error("dll not back on");
    property p_quiet; quiet_reg != 5'h00 |-> sel_nop && cke; endproperty
    a_quiet: assert property (p_quiet) else $error("command in exit wait");
    property p_reentry; sel_sre |-> !need_ref_reg; endproperty
    a_reentry: assert property (p_reentry) else $error("reentry without refresh");
    property p_tccd; sel_col |=> !sel_col; endproperty
    a_tccd: assert property (p_tccd) else $error("column commands too close");
    property p_trfc; rfc_reg != 4'h0 |-> !(sel_ref || sel_act); endproperty
    a_trfc: assert property (p_trfc) else $error("command inside refresh cycle");
    property p_gap; gap_reg <= 16'h891c; endproperty
    a_gap: assert property (p_gap) else $error("refresh gap too long");
    property p_ap_hold; ap_reg > 4'h1 |-> bank_open[ap_bank_reg]; endproperty
    a_ap_hold: assert property (p_ap_hold) else $error("bank closed early");
    property p_ap_close; ap_reg == 4'h1 |=> ##[0:1] !bank_open[ap_bank_reg]; endproperty
    a_ap_close: assert property (p_ap_close) else $error("bank not closed");
    property p_pall; sel_pall |=> ##[0:1] bank_open == 4'h0; endproperty
    a_pall: assert property (p_pall) else $error("banks left open");
endmodule : ddrcmd_properties

// >>> sim/ddrcmd_tb.sv
// Self-checking bench joining controller and device over the command link.
// Assumes the design package, header and interface are compiled first.
`timescale 1ns/1ps
module ddrcmd_tb;
    // ------------------------------------------------------------
    // Instances, tasks and test sequence.
    // ------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bl8 = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, self_refresh, dll_on, col_issue, col_write;
    logic [2:0] al = 3'h0;
    logic [3:0] bank_open;
    logic [12:0] ref_row;
    logic [1:0] col_bank;
    logic [9:0] col_addr;
    logic [15:0] expq[$];
    int cq[$];
    int bad_count = 0, cmp_count = 0, cyc = 0, base = -1;
    always #5 clk = ~clk;
    ddrcmd_if link();
    ddrcmd_ctrl ddrcmd_ctrl_inst (.clk(clk), .rstn(rstn), .pins(link.ctrl), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ddrcmd_dev ddrcmd_dev_inst (.clk(clk), .rstn(rstn), .pins(link.dev), .al(al), .bl8(bl8),
        .bank_open(bank_open), .self_refresh(self_refresh), .dll_on(dll_on), .ref_row(ref_row),
        .col_issue(col_issue), .col_write(col_write), .col_bank(col_bank), .col_addr(col_addr));
    ddrcmd_properties ddrcmd_properties_inst (.clk(clk), .rstn(rstn), .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .odt(link.odt), .ba(link.ba), .addr(link.addr), .al(al), .bl8(bl8),
        .bank_open(bank_open), .self_refresh(self_refresh), .dll_on(dll_on));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [13:0] a,
        input logic o);
        logic [31:0] rd;
        logic err;
        do apb(1'b0, 8'h04, 32'h0, rd, err); while (rd[2] !== 1'b0);
        apb(1'b1, 8'h00, {12'h000, o, op, b, a}, rd, err);
    endtask : cmd
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc
    always @(posedge clk) begin : watch
        logic [15:0] e;
        int d;
        cyc++;
        if (link.cs_n === 1'b0 && link.ras_n && !link.cas_n) cq.push_back(cyc);
        if (col_issue === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            d = cyc - cq.pop_front() - int'(e[15:13]);
            if (base < 0) base = d;
            check("column", {19'h0, e[12:0]}, {19'h0, col_write, col_bank, col_addr});
            check("latency", base, d);
        end else if (col_issue === 1'b1) begin
            check("extra_column", 32'h0, 32'h1);
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin : main
        logic [31:0] rd, w;
        logic er;
        logic [1:0] b;
        logic [12:0] r0;
        w = $urandom(32'h482a);
        waitc(12);
        rstn <= 1'b1;
        @(posedge clk);
        check("bank_open", 32'h0, {28'h0, bank_open});
        check("dll_on", 32'h1, {31'h0, dll_on});
        apb(1'b0, 8'h04, 32'h0, rd, er);
        check("status", 32'h0, {24'h0, rd[9:2]});
        apb(1'b1, 8'h04, 32'h1, rd, er);
        check("status_write", 32'h1, {31'h0, er});
        apb(1'b0, 8'h80, 32'h0, rd, er);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 7; i++) begin
            w = $urandom;
            b = w[1:0];
            al <= 3'(i);
            bl8 <= w[12];
            cmd(3'h1, b, w[27:14], 1'b0);
            waitc(6);
            check("act", 32'h1, {31'h0, bank_open[b]});
            expq.push_back({3'(i), 1'(i), b, w[11:2]});
            cmd(i[0] ? 3'h3 : 3'h2, b, {3'h0, 1'b1, w[11:2]}, 1'b0);
            waitc(40);
            check("auto_pre", 32'h0, {31'h0, bank_open[b]});
        end
        cmd(3'h1, 2'h0, 14'h0000, 1'b0);
        cmd(3'h1, 2'h3, 14'h0005, 1'b0);
        waitc(4);
        for (int i = 0; i < 2; i++) begin
            expq.push_back({3'h6, 1'b0, 2'h0, 10'(i * 8)});
            cmd(3'h2, 2'h0, 14'(i * 8), 1'b0);
        end
        waitc(30);
        check("no_ap", 32'h9, {28'h0, bank_open});
        cmd(3'h0, w[1:0], w[15:2], 1'b0);
        waitc(4);
        check("nop", 32'h9, {28'h0, bank_open});
        cmd(3'h4, w[3:2], w[13:0] | 14'h0400, 1'b0);
        waitc(4);
        check("pre_all", 32'h0, {28'h0, bank_open});
        r0 = ref_row;
        cmd(3'h5, w[5:4], w[17:4], 1'b0);
        waitc(20);
        check("ref_row", {19'h0, r0 + 13'h1}, {19'h0, ref_row});
        cmd(3'h0, 2'h0, 14'h0000, 1'b1);
        cmd(3'h6, 2'h0, 14'h0000, 1'b0);
        waitc(40);
        check("sr_in", 32'h1, {31'h0, self_refresh});
        check("dll_off", 32'h0, {31'h0, dll_on});
        check("odt", 32'h0, {31'h0, link.odt});
        r0 = ref_row;
        waitc(4000);
        check("sr_timer", 32'h1, {31'h0, ref_row !== r0});
        cmd(3'h0, 2'h0, 14'h0000, 1'b0);
        waitc(40);
        check("sr_out", 32'h0, {31'h0, self_refresh});
        check("dll_back", 32'h1, {31'h0, dll_on});
        apb(1'b0, 8'h04, 32'h0, rd, er);
        check("need_ref", 32'h1, {31'h0, rd[9]});
        cmd(3'h6, 2'h0, 14'h0000, 1'b0);
        waitc(40);
        check("refused", 32'h0, {31'h0, self_refresh});
        cmd(3'h5, 2'h0, 14'h0000, 1'b0);
        cmd(3'h6, 2'h0, 14'h0000, 1'b0);
        waitc(40);
        check("sr_again", 32'h1, {31'h0, self_refresh});
        cmd(3'h0, 2'h0, 14'h0000, 1'b0);
        waitc(40);
        r0 = ref_row;
        waitc(9 * 3900 + 100);
        check("posted_ref", 32'h1, {31'h0, ref_row !== r0});
        check("pending", 32'h0, expq.size());
        tally_and_finish();
    end
endmodule : ddrcmd_tb
